//--- rcf_defs.svh
// constants for the reset cause flags block
// Overview of operation
// - enter reset on any listed cause
// - power-up delay lengthens power-on/brown-out reset
// - one register holds a flag per cause except prog_exit; low_power_brownout shares bit 0 with brown-out
// - bit 7 set on stack overflow
// - bit 6 set on stack underflow
// - bit 5 reads zero, ignores writes
// - bit 4 cleared on watchdog reset
// - bit 3 one until pin reset
// - pin reset clears pin reset flag
// - bit 2 cleared by reset instruction
// - bit 1 cleared on power-on reset
// - bit 0 cleared on brown-out reset
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH
`define RCF_ADDR_CAUSE     4'h0
`define RCF_ADDR_CTRL      4'h1
`define RCF_ADDR_IRQ_STAT  4'h2
`define RCF_ADDR_IRQ_CLR   4'h3
`define RCF_ADDR_IRQ_EN    4'h4
`define RCF_BIT_STACK_OVERFLOW_FLAG     7
`define RCF_BIT_STACK_UNDERFLOW_FLAG     6
`define RCF_BIT_WDOG       4
`define RCF_BIT_PIN        3
`define RCF_BIT_INSTR      2
`define RCF_BIT_PWRON      1
`define RCF_BIT_BROWN      0
`define RCF_CAUSE_WMASK    8'hDF
`define RCF_CAUSE_POR_VAL  8'h1C
`define RCF_DELAY_NS       64000
`define RCF_CLK_NS         100
`define RCF_DELAY_CYC      ((`RCF_DELAY_NS + `RCF_CLK_NS - 1) / `RCF_CLK_NS)
`endif

//--- rcf_pkg.sv
// types for the reset cause flags block
package rcf_pkg;
	typedef struct packed {
		logic power_on;
		logic brownout;
		logic low_power_brownout;
		logic pin;
		logic watchdog;
		logic instr;
		logic stack_over;
		logic stack_under;
		logic prog_exit;
	} rcf_cause_type;
	typedef enum logic [2:0] {
		RCF_RUN   = 3'b001,
		RCF_HOLD  = 3'b010,
		RCF_DELAY = 3'b100
	} rcf_state_type;
endpackage : rcf_pkg

//--- rcf_properties.sv
// assertions on the reset cause flag ports
`timescale 1ns/1ps
module rcf_props
	import rcf_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input rcf_cause_type   cause,
	input wire logic [3:0] addr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       dev_reset
);
	wire logic rc = rd && addr == 4'h0;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_cause_resets: assert property (|cause |=> dev_reset)
		else $error("no device reset");
	a_ovf_sets: assert property ($past(cause.stack_over) && rc |=> rdata[7])
		else $error("bit 7 clear");
	a_unf_sets: assert property ($past(cause.stack_under) && rc |=> rdata[6])
		else $error("bit 6 clear");
	a_bit5_zero: assert property (rc |=> !rdata[5])
		else $error("bit 5 set");
	a_wdog_clears: assert property ($past(cause.watchdog) && rc |=> !rdata[4])
		else $error("bit 4 set");
	a_pin_clears: assert property ($past(cause.pin) && rc |=> !rdata[3])
		else $error("bit 3 set");
	a_instr_clears: assert property ($past(cause.instr) && rc |=> !rdata[2])
		else $error("bit 2 set");
	a_pwr_clears: assert property ($past(cause.power_on) && rc |=> !rdata[1])
		else $error("bit 1 set");
	a_brown_clears: assert property ($past(cause.brownout) && rc |=> !rdata[0])
		else $error("bit 0 set");
endmodule : rcf_props
bind rcf_reset_cause rcf_props rcf_props_i (.clk(clk), .rst(rst), .cause(cause), .addr(addr),
	.rd(rd), .rdata(rdata), .dev_reset(dev_reset));

//--- rcf_reset_cause.sv
// reset cause sequencer and flag register
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "rcf_defs.svh"
module rcf_reset_cause
	import rcf_pkg::*;
#(
	parameter int DELAY_CYC = `RCF_DELAY_CYC
)
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  rcf_cause_type      cause,
	input  wire logic [3:0]    addr,
	input  wire logic [7:0]    wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic      [7:0]    rdata,
	output logic               dev_reset,
	output logic               irq
);
	if (DELAY_CYC < 1)
	begin : g_bad_delay
		$error("delay must be at least one cycle");
	end

	rcf_state_type state_reg, state_next;
	logic [31:0]   cnt_reg, cnt_next;
	logic [7:0]    cause_reg, cause_next;
	logic          delay_en_reg, delay_en_next;
	logic [7:0]    stat_reg, stat_next;
	logic [7:0]    en_reg, en_next;
	logic [7:0]    rdata_reg, rdata_next;
	logic          dres_reg, dres_next;
	logic          irq_reg, irq_next;
	logic          any_cause, power_evt;
	logic [7:0]    evt;

	always_comb
	begin
		power_evt = cause.power_on | cause.brownout | cause.low_power_brownout;
		any_cause = power_evt | cause.pin | cause.watchdog | cause.instr
			| cause.stack_over | cause.stack_under | cause.prog_exit;
		evt = {cause.stack_over, cause.stack_under, 1'b0, cause.watchdog,
			cause.pin, cause.instr, cause.power_on, cause.brownout};
	end

	// reset sequencer
	always_comb
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		case (state_reg)
			RCF_RUN:
			begin
				cnt_next = 32'h0000_0000;
				if (any_cause)
				begin
					if (power_evt && delay_en_reg)
						state_next = RCF_DELAY;
					else
						state_next = RCF_HOLD;
				end
			end
			RCF_HOLD:
			begin
				cnt_next = 32'h0000_0000;
				if (power_evt && delay_en_reg)
					state_next = RCF_DELAY;
				else if (!any_cause)
					state_next = RCF_RUN;
			end
			RCF_DELAY:
			begin
				if (power_evt)
					cnt_next = 32'h0000_0000;
				else if (cnt_reg >= 32'(DELAY_CYC - 1))
					state_next = RCF_RUN;
				else
					cnt_next = cnt_reg + 32'h0000_0001;
			end
			default:
				state_next = RCF_HOLD;
		endcase
		dres_next = (state_next != RCF_RUN);
	end

	// cause flags, control and interrupt registers
	always_comb
	begin
		cause_next    = cause_reg;
		delay_en_next = delay_en_reg;
		en_next       = en_reg;
		stat_next     = stat_reg | (evt & `RCF_CAUSE_WMASK);
		if (wr && addr == `RCF_ADDR_CAUSE)
			cause_next = wdata & `RCF_CAUSE_WMASK;
		else if (wr && addr == `RCF_ADDR_CTRL)
			delay_en_next = wdata[0];
		else if (wr && addr == `RCF_ADDR_IRQ_CLR)
			stat_next = (stat_reg & ~wdata) | (evt & `RCF_CAUSE_WMASK);
		else if (wr && addr == `RCF_ADDR_IRQ_EN)
			en_next = wdata & `RCF_CAUSE_WMASK;
		if (power_evt)
		begin
			cause_next = `RCF_CAUSE_POR_VAL;
			if (cause.power_on)
			begin
				cause_next[`RCF_BIT_PWRON] = 1'b0;
				cause_next[`RCF_BIT_BROWN] = 1'b0;
			end
			else
			begin
				cause_next[`RCF_BIT_PWRON] = cause_reg[`RCF_BIT_PWRON];
				cause_next[`RCF_BIT_BROWN] = 1'b0;
			end
		end
		if (cause.stack_over)
			cause_next[`RCF_BIT_STACK_OVERFLOW_FLAG] = 1'b1;
		if (cause.stack_under)
			cause_next[`RCF_BIT_STACK_UNDERFLOW_FLAG] = 1'b1;
		if (cause.watchdog)
			cause_next[`RCF_BIT_WDOG] = 1'b0;
		if (cause.pin)
			cause_next[`RCF_BIT_PIN] = 1'b0;
		if (cause.instr)
			cause_next[`RCF_BIT_INSTR] = 1'b0;
		cause_next[5] = 1'b0;
		irq_next = |(stat_next & en_next);
	end

	// read port
	always_comb
	begin
		rdata_next = 8'h00;
		if (rd && addr == `RCF_ADDR_CAUSE)
			rdata_next = cause_reg;
		else if (rd && addr == `RCF_ADDR_CTRL)
			rdata_next = {7'h00, delay_en_reg};
		else if (rd && addr == `RCF_ADDR_IRQ_STAT)
			rdata_next = stat_reg;
		else if (rd && addr == `RCF_ADDR_IRQ_EN)
			rdata_next = en_reg;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg    <= RCF_HOLD;
			cnt_reg      <= 32'h0000_0000;
			cause_reg    <= `RCF_CAUSE_POR_VAL;
			delay_en_reg <= 1'b1;
			stat_reg     <= 8'h00;
			en_reg       <= 8'h00;
			rdata_reg    <= 8'h00;
			dres_reg     <= 1'b1;
			irq_reg      <= 1'b0;
		end
		else
		begin
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			cause_reg    <= cause_next;
			delay_en_reg <= delay_en_next;
			stat_reg     <= stat_next;
			en_reg       <= en_next;
			rdata_reg    <= rdata_next;
			dres_reg     <= dres_next;
			irq_reg      <= irq_next;
		end
	end

	assign rdata     = rdata_reg;
	assign dev_reset = dres_reg;
	assign irq       = irq_reg;
endmodule : rcf_reset_cause

//--- rcf_testbench.sv
// self-checking bench for the reset cause flags
`timescale 1ns/1ps
module testbench
	import rcf_pkg::*;
;
	logic          clk = 0, rst = 1, wr = 0, rd = 0, dev_reset, irq;
	rcf_cause_type cause = '0;
	logic [3:0]    addr = 4'h0;
	logic [7:0]    wdata = 8'h00, rdata;
	int            bad_count = 0, tests_run = 0, n;
	logic [8:0]    ct [9] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004, 9'h002, 9'h001};
	logic [7:0]    et [9] = '{8'h1C, 8'h1E, 8'h1E, 8'h17, 8'h0F, 8'h1B, 8'h9F, 8'h5F, 8'h1F};
	rcf_reset_cause #(.DELAY_CYC(4)) rcf_reset_cause_i (.clk(clk), .rst(rst), .cause(cause),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dev_reset(dev_reset),
		.irq(irq));
	initial forever #50 clk = ~clk;
	task chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wrr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) addr <= a; wdata <= d; wr <= 1;
		@(posedge clk) wr <= 0;
	endtask : wrr
	task rdc(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk) addr <= a; rd <= 1;
		@(posedge clk) rd <= 0;
		#1 chk(rdata, e);
	endtask : rdc
	task ic(input logic e);
		repeat (2) @(posedge clk);
		#1 chk({7'h0, irq}, {7'h0, e});
	endtask : ic
	task ev(input logic [8:0] c, input logic [7:0] e);
		wrr(4'h0, 8'h1F);
		@(posedge clk) cause <= rcf_cause_type'(c);
		@(posedge clk) cause <= '0; addr <= 4'h0; rd <= 1;
		@(posedge clk) rd <= 0;
		#1 chk(rdata, e);
		n = 0;
		do begin @(posedge clk); #1 n++; end while (dev_reset !== 1'b0 && n < 30);
		chk({7'h0, n > 1}, {7'h0, c[8:6] != 0});
		$display("test cause %h done", c);
	endtask : ev
	task reg_t;
		rdc(4'h0, 8'h1C);
		wrr(4'h0, 8'hFF);
		rdc(4'h0, 8'hDF);
		rdc(4'hF, 8'h00);
		$display("test registers done");
	endtask : reg_t
	task irq_t;
		wrr(4'h3, 8'hFF);
		wrr(4'h4, 8'h10);
		ev(9'h010, 8'h0F);
		ic(1);
		rdc(4'h2, 8'h10);
		wrr(4'h4, 8'h00);
		ic(0);
		wrr(4'h4, 8'h10);
		ic(1);
		wrr(4'h3, 8'h10);
		ic(0);
		$display("test interrupt done");
	endtask : irq_t
	task rst_t;
		@(posedge clk) rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		wait (dev_reset === 1'b0);
		rdc(4'h0, 8'h1C);
		rdc(4'h2, 8'h00);
		$display("test mid-run reset done");
	endtask : rst_t
	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		#200000 bad_count++;
		print_verdict;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 0;
		wait (dev_reset === 1'b0);
		reg_t;
		for (int i = 0; i < 9; i++)
			ev(ct[i], et[i]);
		irq_t;
		rst_t;
		print_verdict;
	end
endmodule : testbench
